// File: spsel_top.sv
// Protocol selection and status word of a serial flash device.
// Commands arrive already decoded from the serial front end on the core
// clock; the write-protect/high-voltage pin and the serial clock come from
// outside and are synchronised here.
`timescale 1ns/1ps
module spsel_top
    import spsel_pkg::*;
#(
    parameter int BUSY_CYCLES = SPSEL_BUSY_CYC
)
(
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         reset,
    // External pins
    input  wire logic         write_protect_pin,
    input  wire logic         serial_clock,
    // Decoded command port
    input  wire logic         cmd_valid,
    input  wire spsel_cmd_s   cmd,
    input  wire logic         evcfg_write,
    input  wire logic [7:0]   evcfg_data,
    input  wire logic         vcfg_write,
    input  wire logic [7:0]   vcfg_data,
    input  wire logic         rescue,
    input  wire logic [15:0]  nvcfg_data,
    input  wire logic         boot,
    // Status and protocol
    output logic [7:0]        device_status_word,
    output spsel_proto_e      protocol,
    output logic [7:0]        working_cfg,
    output logic              cmd_accept,
    output logic              cmd_refused,
    output logic              serial_edge
);
    logic [1:0]  wp_sync_q;
    logic [1:0]  sck_sync_q;
    logic        sck_last_q;
    logic        lock_q;
    logic        tb_q;
    logic [2:0]  bp_q;
    logic        wel_q;
    logic        wip_q;
    logic [15:0] busy_cnt_q;
    logic [7:0]  evcfg_q;
    logic        ev_active_q;
    logic [15:0] nvcfg_q;
    spsel_proto_e base_proto;
    logic        pin_high;
    logic        sr_locked;
    logic        in_region;
    logic        writing_op;
    logic        allow;

    assign pin_high  = wp_sync_q[1];
    assign sr_locked = lock_q && !pin_high;

    // Pins pass two flops before use.
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            wp_sync_q  <= 2'h0;
            sck_sync_q <= 2'h0;
            sck_last_q <= 1'b0;
        end
        else
        begin
            wp_sync_q  <= {wp_sync_q[0], write_protect_pin};
            sck_sync_q <= {sck_sync_q[0], serial_clock};
            sck_last_q <= sck_sync_q[1];
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            serial_edge <= 1'b0;
        else
            serial_edge <= sck_sync_q[1] && !sck_last_q;
    end

    spsel_region u_region
    (
        .top_bottom   (tb_q),
        .protect_size (bp_q),
        .sector       (cmd.sector),
        .in_region    (in_region)
    );

    always_comb
    begin
        writing_op = 1'b0;
        allow      = 1'b0;
        case (cmd.op)
            SPSEL_OP_WREN,
            SPSEL_OP_WRDI:
                allow = !wip_q;
            SPSEL_OP_WRSTAT:
            begin
                writing_op = 1'b1;
                allow = !wip_q && wel_q && !sr_locked;
            end
            SPSEL_OP_WRNVCFG:
            begin
                writing_op = 1'b1;
                allow = !wip_q && wel_q;
            end
            SPSEL_OP_PROG,
            SPSEL_OP_ERASE:
            begin
                writing_op = 1'b1;
                allow = !wip_q && wel_q && !in_region;
            end
            SPSEL_OP_BULK:
            begin
                writing_op = 1'b1;
                allow = !wip_q && wel_q && (bp_q == 3'h0);
            end
            default:
                allow = 1'b0;
        endcase
    end

    // Nonvolatile status bits; reset only models a blank array.
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            {lock_q, tb_q, bp_q} <= SPSEL_SR_NV_RESET;
        else if (cmd_valid && allow && cmd.op == SPSEL_OP_WRSTAT)
        begin
            lock_q <= cmd.data[SPSEL_SR_LOCK];
            tb_q   <= cmd.data[SPSEL_SR_TB];
            bp_q   <= cmd.data[SPSEL_SR_BP_HI:SPSEL_SR_BP_LO];
        end
    end

    // Nonvolatile configuration copy loads when the write command is accepted.
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            nvcfg_q <= SPSEL_NVCFG_RESET;
        else if (cmd_valid && allow && cmd.op == SPSEL_OP_WRNVCFG)
            nvcfg_q <= nvcfg_data;
    end

    // Write-enable latch; a started write operation consumes it.
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            wel_q <= 1'b0;
        else if (cmd_valid && allow)
        begin
            if (cmd.op == SPSEL_OP_WREN)
                wel_q <= 1'b1;
            else
                wel_q <= 1'b0;
        end
    end

    // Busy flag held for a fixed time per write operation.
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            wip_q      <= 1'b0;
            busy_cnt_q <= 16'h0000;
        end
        else if (cmd_valid && allow && writing_op)
        begin
            wip_q      <= 1'b1;
            busy_cnt_q <= 16'(BUSY_CYCLES);
        end
        else if (busy_cnt_q > 16'h0001)
            busy_cnt_q <= busy_cnt_q - 16'h0001;
        else
        begin
            busy_cnt_q <= 16'h0000;
            wip_q      <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            cmd_accept  <= 1'b0;
            cmd_refused <= 1'b0;
        end
        else
        begin
            cmd_accept  <= cmd_valid && allow;
            cmd_refused <= cmd_valid && !allow;
        end
    end

    // Enhanced volatile selection; a rescue drops it.
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            evcfg_q     <= SPSEL_EVCFG_RESET;
            ev_active_q <= 1'b0;
        end
        else if (rescue)
        begin
            evcfg_q     <= SPSEL_EVCFG_RESET;
            ev_active_q <= 1'b0;
        end
        else if (evcfg_write)
        begin
            evcfg_q     <= evcfg_data;
            ev_active_q <= 1'b1;
        end
    end

    always_comb
    begin
        if (!nvcfg_q[SPSEL_NV_QUAD])
            base_proto = SPSEL_PROTO_QUAD;
        else if (!nvcfg_q[SPSEL_NV_DUAL])
            base_proto = SPSEL_PROTO_DUAL;
        else
            base_proto = SPSEL_PROTO_EXT;
    end

    // Boot-time protocol latched at reset release or boot pulse.
    spsel_proto_e boot_proto_q;
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            boot_proto_q <= SPSEL_PROTO_EXT;
        else if (boot || !boot_seen_q)
            boot_proto_q <= base_proto;
    end

    logic boot_seen_q;
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            boot_seen_q <= 1'b0;
        else
            boot_seen_q <= 1'b1;
    end

    spsel_proto_e sel_proto;
    always_comb
    begin
        if (ev_active_q && !evcfg_q[SPSEL_EV_QUAD])
            sel_proto = SPSEL_PROTO_QUAD;
        else if (ev_active_q && !evcfg_q[SPSEL_EV_DUAL])
            sel_proto = SPSEL_PROTO_DUAL;
        else if (!boot_seen_q)
            sel_proto = base_proto;
        else
            sel_proto = boot_proto_q;
    end

    // Quad drops to extended while a high-voltage write runs.
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            protocol <= SPSEL_PROTO_EXT;
        else if (sel_proto == SPSEL_PROTO_QUAD && wip_q && pin_high)
            protocol <= SPSEL_PROTO_EXT;
        else if (!boot_seen_q)
            protocol <= base_proto;
        else
            protocol <= sel_proto;
    end

    // Working configuration: boot from nonvolatile, volatile writes override.
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            working_cfg <= SPSEL_EVCFG_RESET;
        else if (boot || !boot_seen_q)
            working_cfg <= nvcfg_q[15:8];
        else if (evcfg_write)
            working_cfg <= evcfg_data;
        else if (vcfg_write)
            working_cfg <= vcfg_data;
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            device_status_word <= 8'h00;
        else
            device_status_word <= {lock_q, 1'b0, tb_q, bp_q,
                                   wel_q, wip_q};
    end

    // Assertions.
    bulk_guard_a: assert property (@(posedge clock) disable iff (reset)
        (cmd_valid && cmd.op == SPSEL_OP_BULK && bp_q != 3'h0)
        |=> cmd_refused && !cmd_accept)
        else $error("Bulk erase taken with protect bits set.");
    lock_guard_a: assert property (@(posedge clock) disable iff (reset)
        (cmd_valid && cmd.op == SPSEL_OP_WRSTAT && sr_locked)
        |=> $stable(bp_q) && $stable(lock_q))
        else $error("Status changed while locked.");
    wel_need_a: assert property (@(posedge clock) disable iff (reset)
        (cmd_valid && writing_op && !wel_q) |=> !cmd_accept)
        else $error("Write accepted without latch.");
    busy_set_a: assert property (@(posedge clock) disable iff (reset)
        (cmd_valid && allow && writing_op) |=> wip_q ##1
        device_status_word[SPSEL_SR_WIP])
        else $error("Busy flag not raised.");
    rsvd_zero_a: assert property (@(posedge clock) disable iff (reset)
        !device_status_word[SPSEL_SR_RSVD])
        else $error("Reserved status bit set.");
    quad_fall_a: assert property (@(posedge clock) disable iff (reset)
        (sel_proto == SPSEL_PROTO_QUAD && wip_q && pin_high)
        |=> protocol == SPSEL_PROTO_EXT)
        else $error("Quad not relaxed under high voltage.");
    ev_quad_a: assert property (@(posedge clock) disable iff (reset)
        (evcfg_write && !rescue && !evcfg_data[SPSEL_EV_QUAD])
        |=> ##1 (protocol == SPSEL_PROTO_QUAD ||
                 $past(wip_q && pin_high)))
        else $error("Quad not entered after volatile write.");
    ev_dual_a: assert property (@(posedge clock) disable iff (reset)
        (evcfg_write && !rescue && evcfg_data[SPSEL_EV_QUAD]
         && !evcfg_data[SPSEL_EV_DUAL])
        |=> ##1 protocol == SPSEL_PROTO_DUAL)
        else $error("Dual not entered after volatile write.");
    region_a: assert property (@(posedge clock) disable iff (reset)
        (cmd_valid && cmd.op == SPSEL_OP_PROG && in_region)
        |=> cmd_refused)
        else $error("Program inside protected region.");
    rescue_back_a: assert property (@(posedge clock) disable iff (reset)
        (rescue && boot_seen_q) |=> ##1
        (protocol == $past(boot_proto_q) ||
         $past(wip_q && pin_high)))
        else $error("Rescue did not restore the boot protocol.");
    quad_back_a: assert property (@(posedge clock) disable iff (reset)
        (boot_seen_q && sel_proto == SPSEL_PROTO_QUAD && !pin_high)
        |=> protocol == SPSEL_PROTO_QUAD)
        else $error("Quad not resumed with the supply pin low.");
    wel_drop_a: assert property (@(posedge clock) disable iff (reset)
        (cmd_valid && allow && cmd.op != SPSEL_OP_WREN)
        |=> !wel_q)
        else $error("Write-enable latch kept after use.");
endmodule : spsel_top

// File: spsel_pkg.sv
// Constants, types and the contract list for the protocol select and status
// block. Assumes one 25 MHz core clock and an asynchronous reset that stands
// for power-on.
//
// Contract
// - Factory default is extended protocol, single line.
// - Volatile bit6=0, bit7=1 selects dual now.
// - Volatile bit7=0 selects quad at once.
// - Volatile choice reverts at power-on, rescue, rewrite.
// - Nonvolatile bit2 active boots dual protocol.
// - Nonvolatile bit3 zero boots quad protocol.
// - Quad with high supply accepts extended temporarily.
// - Working copy loads from nonvolatile at boot.
// - Volatile writes copy into working register immediately.
// - Status bit7 with pin low blocks writes; the code refuses only the status write command (WRSTAT).
// - Status bit5 selects top or bottom region.
// - Nonzero protect bits refuse writes in region.
// - Whole-array erase only when protect bits zero.
// - Write-enable latch powers up cleared, must set.
// - Status bit0 shows busy during write operations.
// - Volatile status bits clear on reset.
// - Status read and write by dedicated commands.
// - Nonvolatile protocol bits active low, quad wins.
// - Data-modifying commands need prior write enable.
package spsel_pkg;

    typedef enum logic [1:0]
    {
        SPSEL_PROTO_EXT  = 2'b00,
        SPSEL_PROTO_DUAL = 2'b01,
        SPSEL_PROTO_QUAD = 2'b10
    } spsel_proto_e;

    typedef enum logic [2:0]
    {
        SPSEL_OP_NONE    = 3'b000,
        SPSEL_OP_WREN    = 3'b001,
        SPSEL_OP_WRDI    = 3'b010,
        SPSEL_OP_WRSTAT  = 3'b011,
        SPSEL_OP_WRNVCFG = 3'b100,
        SPSEL_OP_PROG    = 3'b101,
        SPSEL_OP_ERASE   = 3'b110,
        SPSEL_OP_BULK    = 3'b111
    } spsel_op_e;

    typedef struct packed
    {
        spsel_op_e  op;
        logic [5:0] sector;
        logic [7:0] data;
    } spsel_cmd_s;

    localparam int SPSEL_SR_LOCK = 7;
    localparam int SPSEL_SR_RSVD = 6;
    localparam int SPSEL_SR_TB   = 5;
    localparam int SPSEL_SR_BP_HI = 4;
    localparam int SPSEL_SR_BP_LO = 2;
    localparam int SPSEL_SR_WEL  = 1;
    localparam int SPSEL_SR_WIP  = 0;
    localparam int SPSEL_NV_DUAL = 2;
    localparam int SPSEL_NV_QUAD = 3;
    localparam int SPSEL_EV_DUAL = 6;
    localparam int SPSEL_EV_QUAD = 7;

    localparam logic [15:0] SPSEL_NVCFG_RESET = 16'hffff;
    localparam logic [7:0]  SPSEL_EVCFG_RESET = 8'hff;
    localparam logic [4:0]  SPSEL_SR_NV_RESET = 5'h00;
    localparam int          SPSEL_SECTORS     = 64;

    localparam int SPSEL_CLK_MHZ    = 25;
    localparam int SPSEL_BUSY_NS    = 2000;
    localparam int SPSEL_BUSY_CYC   = (SPSEL_BUSY_NS * SPSEL_CLK_MHZ) / 1000;

endpackage : spsel_pkg

// File: spsel_region.sv
// Region check: decides whether a sector falls in the protected area.
// Assumes a 64-sector array and combinational use by the main block.
`timescale 1ns/1ps
module spsel_region
    import spsel_pkg::*;
(
    // Protection fields
    input  wire logic       top_bottom,
    input  wire logic [2:0] protect_size,
    // Sector under test
    input  wire logic [5:0] sector,
    output logic            in_region
);
    logic [6:0] span;

    always_comb
    begin
        // Size 0 protects nothing, 7 protects all, else 2^(n-1) sectors.
        span = (protect_size == 3'h0) ? 7'h00 :
               (protect_size == 3'h7) ? 7'h40 :
               7'(7'h01 << (protect_size - 3'h1));
        if (top_bottom)
            in_region = {1'b0, sector} < span;
        else
            in_region = {1'b0, sector} >= (7'h40 - span);
        if (span == 7'h00)
            in_region = 1'b0;
    end
endmodule : spsel_region

// File: spsel_host.sv
// Host side model: makes the serial clock of the link in frames.
// Assumes the bench calls frame; the clock rests low outside frames.
`timescale 1ns/1ps
module spsel_host
(
    // Link clock
    output logic serial_clock
);
    initial serial_clock = 1'b0;

    // Each clock cycle ends with the line driven low, so it is held low between frames.
    task automatic frame(input int n);
        #37;
        repeat (n)
        begin
            #160 serial_clock = 1'b1;
            #160 serial_clock = 1'b0;
        end
    endtask : frame
endmodule : spsel_host

// File: spsel_top_tb.sv
// Self-checking bench for the protocol select and status block.
// Assumes a 25 MHz clock and drives all inputs but the serial clock 1 ns after the rising edge.
`timescale 1ns/1ps
module spsel_top_tb
    import spsel_pkg::*;
;
    logic         clock;
    logic         reset;
    logic         wp;
    logic         sclk;
    logic         cmd_valid;
    spsel_cmd_s   cmd;
    logic         evw;
    logic         vw;
    logic         rescue;
    logic         boot;
    logic [7:0]   evd;
    logic [7:0]   vd;
    logic [15:0]  nvd;
    logic [7:0]   status;
    logic [7:0]   wcfg;
    spsel_proto_e proto;
    logic         acc;
    logic         refu;
    logic         sedge;
    logic [7:0]   sh;
    logic         saw_ext;
    int           miscompares;
    int           checked;
    int           edges;

    spsel_host host (.serial_clock(sclk));

    spsel_top #(.BUSY_CYCLES(8)) dut (
        .clock(clock), .reset(reset), .write_protect_pin(wp),
        .serial_clock(sclk), .cmd_valid(cmd_valid), .cmd(cmd),
        .evcfg_write(evw), .evcfg_data(evd), .vcfg_write(vw),
        .vcfg_data(vd), .rescue(rescue), .nvcfg_data(nvd), .boot(boot),
        .device_status_word(status), .protocol(proto), .working_cfg(wcfg),
        .cmd_accept(acc), .cmd_refused(refu), .serial_edge(sedge));

    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    always @(posedge clock)
        if (sedge === 1'b1) edges <= edges + 1;

    task automatic wrap_up();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    task automatic chk1(input string n, input logic e, input logic g);
        checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("[FAIL] %s exp=%b got=%b", n, e, g);
        end
    endtask : chk1

    task automatic chk8(input string n, input logic [7:0] e,
                        input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("[FAIL] %s exp=%h got=%h", n, e, g);
        end
    endtask : chk8

    task automatic chkp(input spsel_proto_e e);
        checked++;
        if (proto !== e)
        begin
            miscompares++;
            $display("[FAIL] protocol exp=%h got=%h", e, proto);
        end
    endtask : chkp

    function automatic logic in_reg(logic tb, logic [2:0] bp, logic [5:0] s);
        int n;
        n = (bp == 3'h7) ? 64 : ((bp == 3'h0) ? 0 : (1 << (bp - 1)));
        return tb ? (int'(s) < n) : (int'(s) >= 64 - n);
    endfunction : in_reg

    function automatic logic exp_ok(spsel_op_e op, logic [5:0] s);
        if (sh[0])
            return 1'b0;
        case (op)
            SPSEL_OP_WREN, SPSEL_OP_WRDI: return 1'b1;
            SPSEL_OP_WRSTAT: return sh[1] && !(sh[7] && !wp);
            SPSEL_OP_PROG, SPSEL_OP_ERASE:
                return sh[1] && !in_reg(sh[5], sh[4:2], s);
            SPSEL_OP_BULK: return sh[1] && (sh[4:2] == 3'h0);
            default: return sh[1];
        endcase
    endfunction : exp_ok

    task automatic issue(input spsel_op_e op, input logic [5:0] s,
                         input logic [7:0] d);
        logic ok;
        ok = exp_ok(op, s);
        @(posedge clock) #1;
        cmd = '{op, s, d};
        cmd_valid = 1'b1;
        @(posedge clock) #1;
        cmd_valid = 1'b0;
        chk1("accept", ok, acc);
        chk1("refuse", !ok, refu);
        if (ok)
            case (op)
                SPSEL_OP_WREN: sh[1] = 1'b1;
                SPSEL_OP_WRDI: sh[1] = 1'b0;
                SPSEL_OP_WRSTAT: sh = {d[7], 1'b0, d[5:2], 2'b01};
                default: sh[1:0] = 2'b01;
            endcase
        @(posedge clock) #1;
        chk8("status", sh, status);
    endtask : issue

    // Bounded wait for the busy flag to drop, watching the protocol.
    task automatic idle();
        int n;
        n = 0;
        saw_ext = 1'b0;
        while (status[0] !== 1'b0 && n < 40)
        begin
            if (proto === SPSEL_PROTO_EXT) saw_ext = 1'b1;
            @(posedge clock) #1;
            n++;
        end
        sh[0] = 1'b0;
        chk8("status idle", sh, status);
    endtask : idle

    // Kind 0 enhanced volatile, 1 volatile, 2 rescue, 3 boot.
    task automatic poke(input int k, input logic [7:0] d);
        @(posedge clock) #1;
        evd = d;
        vd = d;
        {boot, rescue, vw, evw} = 4'(1 << k);
        @(posedge clock) #1;
        {boot, rescue, vw, evw} = 4'h0;
        repeat (3) @(posedge clock);
        #1;
    endtask : poke

    task automatic wait_n(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : wait_n

    initial
    begin
        #400000;
        miscompares++;
        wrap_up();
    end

    initial
    begin
        logic [7:0]   d;
        logic [5:0]   s;
        logic [15:0]  nv [4];
        logic [7:0]   ev [4];
        spsel_proto_e pn [4];
        spsel_proto_e pe [4];
        int           e0;
        nv = '{16'h5afb, 16'hc3f7, 16'h96f3, 16'hffff};
        pn = '{SPSEL_PROTO_DUAL, SPSEL_PROTO_QUAD, SPSEL_PROTO_QUAD,
               SPSEL_PROTO_EXT};
        ev = '{8'hbf, 8'h7f, 8'h3f, 8'hff};
        pe = '{SPSEL_PROTO_DUAL, SPSEL_PROTO_QUAD, SPSEL_PROTO_QUAD,
               SPSEL_PROTO_EXT};
        {reset, wp, cmd_valid, evw, vw, rescue, boot} = 7'h40;
        cmd = '0;
        {evd, vd, nvd} = '0;
        sh = 8'h00;
        miscompares = 0;
        checked = 0;
        void'($urandom(32'h58fba53d));
        wait_n(8);
        reset = 1'b0;
        wait_n(2);
        chk8("status", 8'h00, status);
        chkp(SPSEL_PROTO_EXT);
        chk8("working", 8'hff, wcfg);
        issue(SPSEL_OP_PROG, 6'h00, 8'h00);
        issue(SPSEL_OP_WREN, 6'h00, 8'h00);
        issue(SPSEL_OP_WRDI, 6'h00, 8'h00);
        for (int i = 0; i < 10; i++)
        begin
            d = 8'($urandom);
            s = 6'($urandom);
            d[7] = 1'b0;
            if (i < 2) d[4:2] = (i == 0) ? 3'h7 : 3'h0;
            if (i == 2) {d[5:2], s} = {4'h1, 6'h3f};
            issue(SPSEL_OP_WREN, 6'h00, 8'h00);
            issue(SPSEL_OP_WRSTAT, 6'h00, d);
            idle();
            issue(SPSEL_OP_WREN, 6'h00, 8'h00);
            issue($urandom % 2 ? SPSEL_OP_PROG : SPSEL_OP_ERASE, s,
                  8'h00);
            issue(SPSEL_OP_WREN, 6'h00, 8'h00);
            idle();
            issue(SPSEL_OP_WREN, 6'h00, 8'h00);
            issue(SPSEL_OP_BULK, s, 8'h00);
            idle();
            issue(SPSEL_OP_WRDI, 6'h00, 8'h00);
        end
        issue(SPSEL_OP_WREN, 6'h00, 8'h00);
        issue(SPSEL_OP_WRSTAT, 6'h00, 8'h80);
        idle();
        issue(SPSEL_OP_WREN, 6'h00, 8'h00);
        issue(SPSEL_OP_WRSTAT, 6'h00, 8'h00);
        wp = 1'b1;
        wait_n(4);
        issue(SPSEL_OP_WRSTAT, 6'h00, 8'h00);
        idle();
        wp = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            poke(0, ev[i]);
            chkp(pe[i]);
            chk8("working", ev[i], wcfg);
        end
        poke(1, 8'ha5);
        chk8("working", 8'ha5, wcfg);
        poke(0, 8'hbf);
        poke(2, 8'h00);
        chkp(SPSEL_PROTO_EXT);
        poke(0, 8'h7f);
        wp = 1'b1;
        wait_n(4);
        issue(SPSEL_OP_WREN, 6'h00, 8'h00);
        issue(SPSEL_OP_PROG, 6'h00, 8'h00);
        idle();
        chk1("ext while busy", 1'b1, saw_ext);
        wp = 1'b0;
        wait_n(5);
        chkp(SPSEL_PROTO_QUAD);
        poke(2, 8'h00);
        chkp(SPSEL_PROTO_EXT);
        for (int i = 0; i < 4; i++)
        begin
            nvd = nv[i];
            issue(SPSEL_OP_WREN, 6'h00, 8'h00);
            issue(SPSEL_OP_WRNVCFG, 6'h00, 8'h00);
            idle();
            poke(3, 8'h00);
            chkp(pn[i]);
            chk8("working", nv[i][15:8], wcfg);
        end
        for (int n = 1; n < 7; n += 4)
        begin
            e0 = edges;
            host.frame(n);
            wait_n(4);
            chk8("serial edges", 8'(n), 8'(edges - e0));
        end
        issue(SPSEL_OP_WREN, 6'h00, 8'h00);
        poke(0, 8'h7f);
        reset = 1'b1;
        wait_n(2);
        reset = 1'b0;
        wait_n(2);
        chk8("status", 8'h00, status);
        chkp(SPSEL_PROTO_EXT);
        chk8("working", 8'hff, wcfg);
        wrap_up();
    end
endmodule : spsel_top_tb
